/* File: hw/sfr_consts.svh */
// constants of the supply fault response block
`ifndef SFR_CONSTS_SVH
`define SFR_CONSTS_SVH

// ----------------------------------------
// clock and delay times
// ----------------------------------------
`define SFR_CLK_NS        100
`define SFR_RD_LONG_US    10000
`define SFR_RD_SHORT_US   2000
`define SFR_RD_LONG_CYC   ((`SFR_RD_LONG_US * 1000) / `SFR_CLK_NS)
`define SFR_RD_SHORT_CYC  ((`SFR_RD_SHORT_US * 1000) / `SFR_CLK_NS)
`define SFR_CNT_W         17
`define SFR_INIT_CYC      2'h3

// ----------------------------------------
// reset values and level meanings
// ----------------------------------------
`define SFR_OV_EN_RST     1'h0
`define SFR_FAIL_FUNC_RST 1'h1
`define SFR_SEL_RESTART   1'h1
`define SFR_CNT_FIRST     1'h1

// ----------------------------------------
// positions in the synchronised pin vector
// ----------------------------------------
`define SFR_PIN_OV        0
`define SFR_PIN_WAKE      1
`define SFR_PIN_SEL       2
`define SFR_PIN_CNT       3
`define SFR_PIN_N         4

`endif

/* File: hw/sfr_pkg.sv */
// types of the supply fault response block
`default_nettype none

package sfr_pkg;
    typedef enum logic [3:0] {
        SFR_INIT     = 4'h1,
        SFR_NORMAL   = 4'h2,
        SFR_RESTART  = 4'h4,
        SFR_FAILSAFE = 4'h8
    } sfr_mode_t;
endpackage

`default_nettype wire

/* File: hw/sfr_delay_if.sv */
// restart delay request and completion between controller and timer
`default_nettype none

interface sfr_delay_if;
    logic start;
    logic short_sel;
    logic done;
    modport ctrl  (output start, output short_sel, input done);
    modport timer (input start, input short_sel, output done);
endinterface

`default_nettype wire

/* File: hw/sfr_restart_timer.sv */
// restart mode delay counter, long or short delay
`include "sfr_consts.svh"
`default_nettype none

module sfr_restart_timer #(
    parameter int LONG_CYC  = `SFR_RD_LONG_CYC,
    parameter int SHORT_CYC = `SFR_RD_SHORT_CYC,
    parameter int CNT_W     = `SFR_CNT_W
) (
    input  wire logic  sys_clk_in,
    input  wire logic  rst_in,
    sfr_delay_if.timer dly
);
    import sfr_pkg::*;

    logic             busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] elapsed_reg;
    logic             sel_reg;

    if (LONG_CYC < 1 || SHORT_CYC < 1 || LONG_CYC >= (2 ** CNT_W)
        || SHORT_CYC >= (2 ** CNT_W)) begin : g_bad_delay
        $error("restart delay does not fit the counter");
    end

    assign dly.done = busy_reg && (cnt_reg == '0);

    // ----------------------------------------
    // countdown, restart lasts exactly the chosen count
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_reg <= 1'h0;
            cnt_reg  <= '0;
            sel_reg  <= 1'h0;
        end else if (dly.start) begin
            busy_reg <= 1'h1;
            sel_reg  <= dly.short_sel;
            cnt_reg  <= dly.short_sel ? CNT_W'(SHORT_CYC - 1) : CNT_W'(LONG_CYC - 1);
        end else if (busy_reg) begin
            if (cnt_reg == '0) begin
                busy_reg <= 1'h0;
            end else begin
                cnt_reg <= cnt_reg - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            elapsed_reg <= '0;
        end else if (dly.start) begin
            elapsed_reg <= '0;
        end else if (busy_reg) begin
            elapsed_reg <= elapsed_reg + CNT_W'(1);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_DELAY_LEN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        dly.done |-> elapsed_reg == (sel_reg ? CNT_W'(SHORT_CYC - 1) : CNT_W'(LONG_CYC - 1)))
        else $error("restart delay length wrong");
endmodule

`default_nettype wire

/* File: hw/sfr_top.sv */
// supervisor reacting to watchdog failure and main supply overvoltage
// Functional notes
// - watchdog failure enters restart or fail-safe after first or second consecutive failure
// - fail output activates together with watchdog-failure mode entry when configured as fail
// - select pin 1 restart, 0 fail-safe; count pin 1 first, 0 second failure
// - multipurpose pin defaults to open-drain active-low fail output
// - overvoltage reaction enable clears on power-on reset, soft reset, restart
// - enable 0: overvoltage only sets status flag, no mode change
// - enable 1: overvoltage sets flag and triggers configured mode change
// - enable 1, latched select 1: overvoltage enters restart, fail output active
// - enable 1, latched select 0: overvoltage enters fail-safe, fail output active
// - fail-safe mode left only on a wake event
// - entering restart clears the overvoltage reaction enable
// - restart mode ends after long reset delay, typically 10 ms
// - optional short restart delay, typically 2 ms
// - after restart stay in normal mode though overvoltage persists
// - overvoltage flag stays set until microcontroller clears it
// - renewed restart on overvoltage only after enable is set again
`include "sfr_consts.svh"
`default_nettype none

module sfr_top #(
    parameter int RD_LONG_CYC  = `SFR_RD_LONG_CYC,
    parameter int RD_SHORT_CYC = `SFR_RD_SHORT_CYC
) (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_in,
    input  wire logic          wd_fail_in,
    input  wire logic          wd_ok_in,
    input  wire logic          overvoltage_in,
    input  wire logic          wake_in,
    input  wire logic          reaction_select_pin_level_in,
    input  wire logic          fail_count_pin_level_in,
    input  wire logic          soft_reset_in,
    input  wire logic          ov_enable_wr_in,
    input  wire logic          ov_enable_wdata_in,
    input  wire logic          ov_flag_clr_in,
    input  wire logic          fail_clr_in,
    input  wire logic          pin_cfg_wr_in,
    input  wire logic          pin_cfg_fail_in,
    input  wire logic          short_delay_sel_in,
    input  wire logic          fail_multipurpose_pin_in,
    output logic               fail_multipurpose_pin_out,
    output logic               fail_multipurpose_pin_oe_out,
    output logic               reset_out_low_out,
    output logic               overvoltage_reaction_enable_out,
    output logic               main_supply_overvoltage_flag_out,
    output logic               latched_mode_select_level_out,
    output logic               fail_count_first_out,
    output logic               pin_is_fail_out,
    output sfr_pkg::sfr_mode_t mode_out
);
    import sfr_pkg::*;

    logic [`SFR_PIN_N-1:0] sync1_reg;
    logic [`SFR_PIN_N-1:0] sync2_reg;
    logic [1:0]            init_cnt_reg;
    sfr_mode_t             state_reg;
    sfr_mode_t             state_next;
    logic                  sel_reg;
    logic                  cnt_first_reg;
    logic                  wd_seen_reg;
    logic                  ov_en_reg;
    logic                  ov_flag_reg;
    logic                  fail_active_reg;
    logic                  pin_fail_reg;
    logic                  rst_low_reg;
    logic                  pin_unused;
    logic                  ov_s;
    logic                  wake_s;
    logic                  in_normal;
    logic                  wd_trip;
    logic                  ov_trip;
    logic                  trip;
    logic                  go_restart;
    logic                  go_failsafe;

    sfr_delay_if dly ();

    sfr_restart_timer #(
        .LONG_CYC  (RD_LONG_CYC),
        .SHORT_CYC (RD_SHORT_CYC),
        .CNT_W     (`SFR_CNT_W)
    ) u_timer (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .dly        (dly)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {fail_count_pin_level_in, reaction_select_pin_level_in,
                          wake_in, overvoltage_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign ov_s       = sync2_reg[`SFR_PIN_OV];
    assign wake_s     = sync2_reg[`SFR_PIN_WAKE];
    assign pin_unused = fail_multipurpose_pin_in;

    // ----------------------------------------
    // event decode
    // ----------------------------------------
    assign in_normal   = (state_reg == SFR_NORMAL);
    assign wd_trip     = in_normal && wd_fail_in && (cnt_first_reg || wd_seen_reg);
    assign ov_trip     = in_normal && ov_s && ov_en_reg;
    assign trip        = wd_trip || ov_trip;
    assign go_restart  = (trip && sel_reg)
                         || ((state_reg == SFR_FAILSAFE) && wake_s);
    assign go_failsafe = trip && !sel_reg;

    assign dly.start     = go_restart;
    assign dly.short_sel = short_delay_sel_in;

    // ----------------------------------------
    // mode sequencing
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SFR_INIT: begin
                if (init_cnt_reg == `SFR_INIT_CYC) begin
                    state_next = SFR_NORMAL;
                end
            end
            SFR_NORMAL: begin
                if (go_restart) begin
                    state_next = SFR_RESTART;
                end else if (go_failsafe) begin
                    state_next = SFR_FAILSAFE;
                end
            end
            SFR_RESTART: begin
                if (dly.done) begin
                    state_next = SFR_NORMAL;
                end
            end
            SFR_FAILSAFE: begin
                if (go_restart) begin
                    state_next = SFR_RESTART;
                end
            end
            default: begin
                state_next = SFR_INIT;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SFR_INIT;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // configuration capture after reset release
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            init_cnt_reg <= 2'h0;
        end else if (state_reg == SFR_INIT && init_cnt_reg != `SFR_INIT_CYC) begin
            init_cnt_reg <= init_cnt_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_reg       <= 1'h0;
            cnt_first_reg <= 1'h0;
        end else if (state_reg == SFR_INIT && init_cnt_reg == `SFR_INIT_CYC) begin
            sel_reg       <= (sync2_reg[`SFR_PIN_SEL] == `SFR_SEL_RESTART);
            cnt_first_reg <= (sync2_reg[`SFR_PIN_CNT] == `SFR_CNT_FIRST);
        end
    end

    // ----------------------------------------
    // consecutive watchdog failure memory
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wd_seen_reg <= 1'h0;
        end else if (!in_normal || wd_trip) begin
            wd_seen_reg <= 1'h0;
        end else if (wd_fail_in) begin
            wd_seen_reg <= 1'h1;
        end else if (wd_ok_in) begin
            wd_seen_reg <= 1'h0;
        end
    end

    // ----------------------------------------
    // overvoltage reaction enable and status flag
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ov_en_reg <= `SFR_OV_EN_RST;
        end else if (soft_reset_in || go_restart) begin
            ov_en_reg <= `SFR_OV_EN_RST;
        end else if (ov_enable_wr_in) begin
            ov_en_reg <= ov_enable_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ov_flag_reg <= 1'h0;
        end else if (ov_s) begin
            ov_flag_reg <= 1'h1;
        end else if (ov_flag_clr_in) begin
            ov_flag_reg <= 1'h0;
        end
    end

    // ----------------------------------------
    // fail output pin, open drain active low
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_fail_reg <= `SFR_FAIL_FUNC_RST;
        end else if (pin_cfg_wr_in) begin
            pin_fail_reg <= pin_cfg_fail_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            fail_active_reg <= 1'h0;
        end else if (trip && pin_fail_reg) begin
            fail_active_reg <= 1'h1;
        end else if (fail_clr_in || !pin_fail_reg) begin
            fail_active_reg <= 1'h0;
        end
    end

    assign fail_multipurpose_pin_out    = 1'h0;
    assign fail_multipurpose_pin_oe_out = fail_active_reg;

    // ----------------------------------------
    // reset output toward the controller
    // ----------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_low_reg <= 1'h0;
        end else begin
            rst_low_reg <= (state_next == SFR_NORMAL);
        end
    end

    assign reset_out_low_out                = rst_low_reg;
    assign overvoltage_reaction_enable_out  = ov_en_reg;
    assign main_supply_overvoltage_flag_out = ov_flag_reg;
    assign latched_mode_select_level_out    = sel_reg;
    assign fail_count_first_out             = cnt_first_reg;
    assign pin_is_fail_out                  = pin_fail_reg;
    assign mode_out                         = state_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    AST_WD_FIRST: assert property (
        in_normal && wd_fail_in && cnt_first_reg |=> state_reg != SFR_NORMAL)
        else $error("first watchdog failure ignored");
    AST_WD_SECOND: assert property (
        in_normal && wd_fail_in && !cnt_first_reg && !wd_seen_reg && !ov_trip
        |=> state_reg == SFR_NORMAL ##0 wd_seen_reg)
        else $error("single failure reacted under second-failure count");
    AST_FAIL_PIN: assert property (
        trip && pin_fail_reg |=> fail_multipurpose_pin_oe_out && !fail_multipurpose_pin_out)
        else $error("fail output not driven low on failure");
    AST_OV_ONLY_FLAG: assert property (
        in_normal && ov_s && !ov_en_reg && !wd_trip
        |=> state_reg == SFR_NORMAL && main_supply_overvoltage_flag_out)
        else $error("disabled overvoltage changed mode");
    AST_OV_RESTART: assert property (
        ov_trip && sel_reg |=> state_reg == SFR_RESTART && !overvoltage_reaction_enable_out)
        else $error("overvoltage restart or enable clear missing");
    AST_OV_FAILSAFE: assert property (
        ov_trip && !sel_reg |=> state_reg == SFR_FAILSAFE)
        else $error("overvoltage fail-safe entry missing");
    AST_FS_HOLD: assert property (
        state_reg == SFR_FAILSAFE && !wake_s |=> state_reg == SFR_FAILSAFE)
        else $error("fail-safe left without wake");
    AST_SOFT_CLR: assert property (
        soft_reset_in |=> !overvoltage_reaction_enable_out)
        else $error("soft reset kept enable");
    AST_FLAG_HOLD: assert property (
        main_supply_overvoltage_flag_out && !ov_flag_clr_in
        |=> main_supply_overvoltage_flag_out)
        else $error("overvoltage flag lost without clear");
    AST_RST_LOW: assert property (
        state_reg == SFR_RESTART |-> !reset_out_low_out)
        else $error("reset output released in restart");
    AST_STAY_NORMAL: assert property (
        $fell(state_reg == SFR_RESTART) |-> in_normal && !ov_en_reg
        ##1 (in_normal || $past(wd_trip) || $past(wd_trip, 2)) [*2])
        else $error("left normal after restart without enable");

    COV_OV_RESTART: cover property (ov_trip && sel_reg);
    COV_OV_FAILSAFE: cover property (ov_trip && !sel_reg);
    COV_WD_SECOND: cover property (wd_trip && !cnt_first_reg);
    COV_WAKE_EXIT: cover property (state_reg == SFR_FAILSAFE && wake_s);
endmodule

`default_nettype wire

/* File: tb/sfr_mcu_model.sv */
// controller-side model: watchdog events, control writes and status clears
`default_nettype none

module sfr_mcu_model (
    input  wire logic sys_clk_in,
    input  wire logic reset_out_low_in,
    output logic      wd_fail_out,
    output logic      wd_ok_out,
    output logic      soft_reset_out,
    output logic      ov_enable_wr_out,
    output logic      ov_enable_wdata_out,
    output logic      ov_flag_clr_out,
    output logic      fail_clr_out,
    output logic      pin_cfg_wr_out,
    output logic      pin_cfg_fail_out,
    output logic      short_delay_sel_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        wd_fail_out = 1'h0;
        wd_ok_out = 1'h0;
        soft_reset_out = 1'h0;
        ov_enable_wr_out = 1'h0;
        ov_enable_wdata_out = 1'h0;
        ov_flag_clr_out = 1'h0;
        fail_clr_out = 1'h0;
        pin_cfg_wr_out = 1'h0;
        pin_cfg_fail_out = 1'h0;
        short_delay_sel_out = 1'h0;
    end

    // one-cycle strobe, except short delay select which stays at the given level; writes are lost while the controller is held in reset
    task automatic strobe(input int which, input logic val);
        @(negedge sys_clk_in);
        if (which >= 2 && reset_out_low_in !== 1'h1) return;
        case (which)
            0: wd_fail_out = 1'h1;
            1: wd_ok_out = 1'h1;
            2: soft_reset_out = 1'h1;
            3: begin
                ov_enable_wr_out = 1'h1;
                ov_enable_wdata_out = val;
            end
            4: ov_flag_clr_out = 1'h1;
            5: fail_clr_out = 1'h1;
            6: begin
                pin_cfg_wr_out = 1'h1;
                pin_cfg_fail_out = val;
            end
            default: short_delay_sel_out = val;
        endcase
        @(negedge sys_clk_in);
        {wd_fail_out, wd_ok_out, soft_reset_out} = 3'h0;
        {ov_enable_wr_out, ov_flag_clr_out, fail_clr_out, pin_cfg_wr_out} = 4'h0;
        // released data lines do not keep the old value
        ov_enable_wdata_out = ~ov_enable_wdata_out;
        pin_cfg_fail_out = ~pin_cfg_fail_out;
    endtask
endmodule

`default_nettype wire

/* File: tb/supply_fault_mode_response_tb_top.sv */
// bench for the supply fault response block
`default_nettype none

module supply_fault_mode_response_tb_top import sfr_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int LONG = 20;
    localparam int SHORT = 6;

    typedef struct {
        logic       sel;
        logic       cnt;
        logic       use_ov;
        logic       en;
        logic [3:0] exp;
    } sfr_row_t;

    logic       clk, rst, ov, wake, sel, cnt;
    logic       wd_fail, wd_ok, soft_rst, en_wr, en_wd, flag_clr, fail_clr;
    logic       pin_wr, pin_fail, short_sel;
    logic       pin_o, pin_oe, rst_low, en_o, flag_o, lsel_o, lcnt_o, is_fail_o;
    sfr_mode_t  mode_o;
    wire logic  pin_level;
    int         err_count, n_compared, cycles, n;

    // pull-up on the open-drain pin
    assign pin_level = pin_oe ? pin_o : 1'h1;

    sfr_top #(.RD_LONG_CYC(LONG), .RD_SHORT_CYC(SHORT)) sfr_top_i (
        .sys_clk_in(clk), .rst_in(rst), .wd_fail_in(wd_fail), .wd_ok_in(wd_ok),
        .overvoltage_in(ov), .wake_in(wake), .reaction_select_pin_level_in(sel),
        .fail_count_pin_level_in(cnt), .soft_reset_in(soft_rst),
        .ov_enable_wr_in(en_wr), .ov_enable_wdata_in(en_wd), .ov_flag_clr_in(flag_clr),
        .fail_clr_in(fail_clr), .pin_cfg_wr_in(pin_wr), .pin_cfg_fail_in(pin_fail),
        .short_delay_sel_in(short_sel), .fail_multipurpose_pin_in(pin_level),
        .fail_multipurpose_pin_out(pin_o), .fail_multipurpose_pin_oe_out(pin_oe),
        .reset_out_low_out(rst_low), .overvoltage_reaction_enable_out(en_o),
        .main_supply_overvoltage_flag_out(flag_o), .latched_mode_select_level_out(lsel_o),
        .fail_count_first_out(lcnt_o), .pin_is_fail_out(is_fail_o), .mode_out(mode_o));

    sfr_mcu_model sfr_mcu_model_i (
        .sys_clk_in(clk), .reset_out_low_in(rst_low), .wd_fail_out(wd_fail),
        .wd_ok_out(wd_ok), .soft_reset_out(soft_rst), .ov_enable_wr_out(en_wr),
        .ov_enable_wdata_out(en_wd), .ov_flag_clr_out(flag_clr), .fail_clr_out(fail_clr),
        .pin_cfg_wr_out(pin_wr), .pin_cfg_fail_out(pin_fail),
        .short_delay_sel_out(short_sel));

    // ------------------------------------------------------------
    // clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 4000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic expect_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, what, got);
        end
    endtask

    task automatic do_reset(input logic s, input logic c);
        rst = 1'h1;
        sel = s;
        cnt = c;
        ov = 1'h0;
        wake = 1'h0;
        repeat (10) @(negedge clk);
        expect_val(mode_o, SFR_INIT, "mode in reset");
        expect_val(rst_low, 1'h0, "reset out in reset");
        rst = 1'h0;
        wait_mode(SFR_NORMAL);
        expect_val(mode_o, SFR_NORMAL, "mode after reset");
        expect_val({lsel_o, lcnt_o, rst_low}, {s, c, 1'h1}, "latched straps");
        expect_val({en_o, flag_o, is_fail_o, pin_oe}, 4'h2, "reset values");
    endtask

    task automatic wait_mode(input logic [3:0] m);
        n = 0;
        while (mode_o !== m && n < 8) begin
            n++;
            @(negedge clk);
        end
    endtask

    task automatic restart_len(input int exp);
        n = 0;
        while (mode_o === SFR_RESTART && n < 100) begin
            n++;
            @(negedge clk);
        end
        expect_val(n == exp, 1'h1, "restart length");
        expect_val({mode_o, rst_low}, {SFR_NORMAL, 1'h1}, "after restart");
    endtask

    // ------------------------------------------------------------
    // table cases: strap levels against fault source
    // ------------------------------------------------------------
    sfr_row_t rows[7] = '{
        '{1'h1, 1'h1, 1'h0, 1'h0, SFR_RESTART},
        '{1'h0, 1'h1, 1'h0, 1'h0, SFR_FAILSAFE},
        '{1'h1, 1'h0, 1'h0, 1'h0, SFR_RESTART},
        '{1'h0, 1'h0, 1'h0, 1'h0, SFR_FAILSAFE},
        '{1'h1, 1'h0, 1'h1, 1'h0, SFR_NORMAL},
        '{1'h1, 1'h0, 1'h1, 1'h1, SFR_RESTART},
        '{1'h0, 1'h1, 1'h1, 1'h1, SFR_FAILSAFE}};

    initial begin
        {rst, ov, wake, sel, cnt} = 5'h10;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        foreach (rows[i]) begin
            do_reset(rows[i].sel, rows[i].cnt);
            if (rows[i].use_ov) begin
                sfr_mcu_model_i.strobe(3, rows[i].en);
                expect_val(en_o, rows[i].en, "enable write");
                ov = 1'h1;
                // two sync edges, then flag and reaction on the third
                repeat (3) @(negedge clk);
                expect_val(flag_o, 1'h1, "overvoltage flag");
            end else begin
                if (!rows[i].cnt) begin
                    sfr_mcu_model_i.strobe(0, 1'h0);
                    expect_val(mode_o, SFR_NORMAL, "first failure");
                end
                sfr_mcu_model_i.strobe(0, 1'h0);
            end
            expect_val(mode_o, rows[i].exp, "mode entry");
            if (rows[i].exp != SFR_NORMAL) begin
                expect_val({pin_oe, pin_level}, 2'h2, "fail pin active low");
                expect_val(rst_low, 1'h0, "reset out");
            end
            if (rows[i].exp == SFR_FAILSAFE) begin
                repeat (30) @(negedge clk);
                expect_val(mode_o, SFR_FAILSAFE, "failsafe hold");
                wake = 1'h1;
                wait_mode(SFR_RESTART);
                wake = 1'h0;
            end
            expect_val(en_o, 1'h0, "enable after entry");
            if (mode_o === SFR_RESTART) restart_len(LONG);
            ov = 1'h0;
        end

        // ------------------------------------------------------------
        // good trigger, fail clear, pin function, short delay
        // ------------------------------------------------------------
        do_reset(1'h1, 1'h0);
        sfr_mcu_model_i.strobe(0, 1'h0);
        sfr_mcu_model_i.strobe(1, 1'h0);
        sfr_mcu_model_i.strobe(0, 1'h0);
        expect_val(mode_o, SFR_NORMAL, "failures not consecutive");
        sfr_mcu_model_i.strobe(0, 1'h0);
        expect_val(mode_o, SFR_RESTART, "second consecutive failure");
        restart_len(LONG);
        sfr_mcu_model_i.strobe(5, 1'h0);
        expect_val(pin_oe, 1'h0, "fail clear");
        sfr_mcu_model_i.strobe(6, 1'h0);
        sfr_mcu_model_i.strobe(7, 1'h1);
        sfr_mcu_model_i.strobe(0, 1'h0);
        sfr_mcu_model_i.strobe(0, 1'h0);
        expect_val({mode_o, pin_oe}, {SFR_RESTART, 1'h0}, "pin not fail");
        restart_len(SHORT);

        // ------------------------------------------------------------
        // overvoltage: soft reset, persistence, flag clear, re-arm
        // ------------------------------------------------------------
        do_reset(1'h1, 1'h0);
        sfr_mcu_model_i.strobe(7, 1'h0);
        sfr_mcu_model_i.strobe(3, 1'h1);
        sfr_mcu_model_i.strobe(2, 1'h0);
        expect_val(en_o, 1'h0, "soft reset clears enable");
        sfr_mcu_model_i.strobe(3, 1'h1);
        ov = 1'h1;
        wait_mode(SFR_RESTART);
        expect_val({mode_o, en_o}, {SFR_RESTART, 1'h0}, "overvoltage restart");
        restart_len(LONG);
        repeat (30) @(negedge clk);
        expect_val({mode_o, flag_o}, {SFR_NORMAL, 1'h1}, "stays normal");
        sfr_mcu_model_i.strobe(4, 1'h0);
        expect_val(flag_o, 1'h1, "flag set wins");
        ov = 1'h0;
        repeat (4) @(negedge clk);
        sfr_mcu_model_i.strobe(4, 1'h0);
        expect_val(flag_o, 1'h0, "flag cleared");
        ov = 1'h1;
        repeat (6) @(negedge clk);
        expect_val({mode_o, flag_o}, {SFR_NORMAL, 1'h1}, "not re-armed");
        ov = 1'h0;
        repeat (4) @(negedge clk);
        sfr_mcu_model_i.strobe(3, 1'h1);
        ov = 1'h1;
        wait_mode(SFR_RESTART);
        expect_val(mode_o, SFR_RESTART, "re-armed restart");
        ov = 1'h0;
        restart_len(LONG);
        print_verdict();
    end
endmodule

`default_nettype wire
